// ### core/bridge_pkg.sv
// shared constants and types for the serial-link register bridge
package bridge_pkg;

  // -------------------------------------------------------------
  // clock and timing
  // -------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BAUD_RATE = 4800;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int unsigned CTRL_CLK_HZ = 4_000_000;
  localparam int unsigned CTRL_TICK_CYCLES = CLK_HZ / CTRL_CLK_HZ;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned TICK_W = 6;

  // -------------------------------------------------------------
  // character framing and word layout
  // -------------------------------------------------------------
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FRAME_BITS = 10;
  localparam int unsigned CMD_BITS = 8;
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned WORD_BYTES = 3;
  localparam logic [5:0] WRITE_SHIFT_BITS = 6'h20;
  localparam logic [5:0] READ_CMD_BITS = 6'h08;
  localparam logic [5:0] READ_DATA_BITS = 6'h18;
  localparam logic [1:0] LAST_BYTE = 2'h2;
  localparam logic [23:0] WORD_RESET = 24'h00_0000;

  // -------------------------------------------------------------
  // command codes
  // -------------------------------------------------------------
  localparam logic [7:0] READ_CONV = 8'h50;
  localparam logic [7:0] READ_CONFIG = 8'h51;
  localparam logic [7:0] READ_GAIN = 8'h52;
  localparam logic [7:0] READ_DAC = 8'h53;
  localparam logic [7:0] READ_IN_RATIO_OFS = 8'h54;
  localparam logic [7:0] READ_IN_ABS_OFS = 8'h55;
  localparam logic [7:0] READ_REF_ABS_OFS = 8'h56;
  localparam logic [7:0] WRITE_CONFIG = 8'hD1;
  localparam logic [7:0] WRITE_GAIN = 8'hD2;
  localparam logic [7:0] WRITE_DAC = 8'hD3;
  localparam logic [7:0] WRITE_IN_RATIO_OFS = 8'hD4;
  localparam logic [7:0] WRITE_IN_ABS_OFS = 8'hD5;
  localparam logic [7:0] WRITE_REF_ABS_OFS = 8'hD6;

  // -------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------
  typedef struct packed {
    logic shift_clock;
    logic serial_in_line;
    logic select_low;
  } port_pins_t;

  localparam port_pins_t PINS_IDLE = '{shift_clock: 1'b0, serial_in_line: 1'b0,
                                       select_low: 1'b1};

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } host_byte_t;

endpackage

// ### core/host_uart.sv
// asynchronous character transmitter and receiver for the host link
`timescale 1ns/1ps
module host_uart #(
  parameter int unsigned BIT_CYCLES = bridge_pkg::BIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic line_rx_in,
  output logic line_tx_out,
  output bridge_pkg::host_byte_t rx_byte_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);

  localparam logic [19:0] BIT_LAST = 20'(BIT_CYCLES - 1);
  localparam logic [19:0] HALF_BIT = 20'(BIT_CYCLES / 2);

  // -------------------------------------------------------------
  // receive pin synchroniser
  // -------------------------------------------------------------
  logic rx_meta;
  logic rx_sync;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= line_rx_in;
      rx_sync <= rx_meta;
    end
  end

  // -------------------------------------------------------------
  // receiver: start, eight data bits lsb first, one stop bit
  // -------------------------------------------------------------
  logic rx_busy;
  logic [19:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_shift;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_busy <= 1'b0;
      rx_cnt <= 20'h0_0000;
      rx_bit <= 4'h0;
      rx_shift <= 8'h00;
      rx_byte_out <= '0;
    end else begin
      rx_byte_out.valid <= 1'b0;
      if (!rx_busy) begin
        // first sample lands mid-bit, so count half a bit from the start edge
        if (!rx_sync) begin
          rx_busy <= 1'b1;
          rx_cnt <= HALF_BIT;
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt != BIT_LAST) begin
        rx_cnt <= rx_cnt + 20'h0_0001;
      end else begin
        rx_cnt <= 20'h0_0000;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          rx_busy <= !rx_sync; // glitch shorter than half a bit is dropped
        end else if (rx_bit < 4'h9) begin
          rx_shift <= {rx_sync, rx_shift[7:1]}; // lsb arrives first [R1]
        end else begin
          rx_busy <= 1'b0;
          rx_byte_out.valid <= rx_sync; // bad stop bit discards the character [R1]
          rx_byte_out.data <= rx_shift;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // transmitter: same framing, idle line high
  // -------------------------------------------------------------
  logic [9:0] tx_frame;
  logic [3:0] tx_left;
  logic [19:0] tx_cnt;

  assign tx_ready_out = (tx_left == 4'h0);
  assign line_tx_out = tx_frame[0];

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_frame <= 10'h3FF;
      tx_left <= 4'h0;
      tx_cnt <= 20'h0_0000;
    end else if (tx_left == 4'h0) begin
      if (tx_valid_in) begin
        tx_frame <= {1'b1, tx_data_in, 1'b0}; // stop, data, start [R1]
        tx_left <= 4'(bridge_pkg::FRAME_BITS);
        tx_cnt <= 20'h0_0000;
      end
    end else if (tx_cnt != BIT_LAST) begin
      tx_cnt <= tx_cnt + 20'h0_0001;
    end else begin
      tx_cnt <= 20'h0_0000;
      tx_frame <= {1'b1, tx_frame[9:1]};
      tx_left <= tx_left - 4'h1;
    end
  end

endmodule // host_uart

// ### core/rs232_register_bridge.sv
// host command interpreter driving the converter's synchronous serial port
// Behaviour
// (R1) host characters use 4800 baud, eight data bits, no parity and one stop bit.
// (R2) a write is one command byte followed by exactly three data bytes forming 24 bits.
// (R3) the three bytes of a word travel lowest byte first, each byte lsb first.
// (R4) write codes D1..D6 select configuration, gain, dac and the three offset registers.
// (R5) read codes 50..56 select conversion data and the six calibration registers.
// (R6) in conversion mode the converter pulls its ready line low once per 81,920 clocks.
// (R7) the ready line goes high once data is shifted out, during load, calibration or sleep.
// (R8) the command word shifted in decides whether conversion or calibration data comes out.
// (R9) with the wire select low the converter floats its output when not sending.
// (R10) every bit read needs one shift clock pulse from this controller.
// (R11) the controller logic runs at 4 MHz derived from the converter's clock; this design divides its 4 MHz enable from the system clock.
// (R12) new conversion words arrive at 50 Hz and reading must keep up.
// (R13) converter reset clears calibration and returns its port to command mode.
// (R14) wire select low picks the four or five wire port, high the three wire port.
// (R15) a new convolution starts after the 24th shift clock falls.
// (R16) a read returns the 24-bit value as three bytes, lowest byte first.
`timescale 1ns/1ps
module rs232_register_bridge #(
  parameter int unsigned BIT_CYCLES = bridge_pkg::BIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic host_rx_in,
  output logic host_tx_out,
  input wire logic result_ready_low_in,
  input wire logic serial_out_line_in,
  output bridge_pkg::port_pins_t port_pins_out,
  output logic port_wire_select_out,
  output logic converter_reset_out
);

  // -------------------------------------------------------------
  // command decoding
  // -------------------------------------------------------------
  function automatic logic is_write(input logic [7:0] code);
    is_write = (code >= bridge_pkg::WRITE_CONFIG) &&
               (code <= bridge_pkg::WRITE_REF_ABS_OFS); // [R4]
  endfunction

  function automatic logic is_read(input logic [7:0] code);
    is_read = (code >= bridge_pkg::READ_CONV) &&
              (code <= bridge_pkg::READ_REF_ABS_OFS); // [R5]
  endfunction

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_COLLECT = 3'b001,
    ST_CMD_SHIFT = 3'b010,
    ST_WAIT_READY = 3'b011,
    ST_DATA_SHIFT = 3'b100,
    ST_REPLY = 3'b101
  } state_t;

  state_t state;
  bridge_pkg::host_byte_t rx_byte;
  logic tx_ready;
  logic tx_valid;
  logic [7:0] cmd;
  logic [23:0] word;
  logic [23:0] next_word;
  logic [31:0] shreg;
  logic [5:0] bits_left;
  logic phase;
  logic [1:0] byte_idx;
  logic [5:0] tick_cnt;
  logic tick;
  logic serial_out_meta;
  logic serial_out_sync;
  logic rdy_meta;
  logic rdy_sync;

  // -------------------------------------------------------------
  // host link
  // -------------------------------------------------------------
  host_uart #(
    .BIT_CYCLES(BIT_CYCLES)
  ) link (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .line_rx_in(host_rx_in),
    .line_tx_out(host_tx_out),
    .rx_byte_out(rx_byte),
    .tx_valid_in(tx_valid),
    .tx_data_in(word[7:0]),
    .tx_ready_out(tx_ready)
  );

  // reply bytes are offered straight from the word register
  assign tx_valid = (state == ST_REPLY);

  // incoming byte fills the top, so the first byte ends up lowest [R3]
  assign next_word = {rx_byte.data, word[23:8]};

  // -------------------------------------------------------------
  // 4 MHz controller enable from the system clock
  // -------------------------------------------------------------
  // one enable instead of a second clock keeps the design in one domain
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tick_cnt <= 6'h00;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 6'(bridge_pkg::CTRL_TICK_CYCLES - 1)); // [R11]
      if (tick_cnt == 6'(bridge_pkg::CTRL_TICK_CYCLES - 1)) begin
        tick_cnt <= 6'h00;
      end else begin
        tick_cnt <= tick_cnt + 6'h01;
      end
    end
  end

  // -------------------------------------------------------------
  // converter pin synchronisers
  // -------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      serial_out_meta <= 1'b0;
      serial_out_sync <= 1'b0;
      rdy_meta <= 1'b1;
      rdy_sync <= 1'b1;
    end else begin
      serial_out_meta <= serial_out_line_in;
      serial_out_sync <= serial_out_meta;
      rdy_meta <= result_ready_low_in;
      rdy_sync <= rdy_meta;
    end
  end

  // -------------------------------------------------------------
  // converter reset and port style
  // -------------------------------------------------------------
  // converter is held in reset with us, so its port starts in command mode
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      converter_reset_out <= 1'b1; // [R13]
      port_wire_select_out <= 1'b0; // four-wire port with chip select [R14]
    end else begin
      converter_reset_out <= 1'b0;
      port_wire_select_out <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // command sequencer and serial port shifter
  // -------------------------------------------------------------
  // bytes arriving while a command is still running are dropped
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
      cmd <= 8'h00;
      word <= bridge_pkg::WORD_RESET;
      shreg <= 32'h0000_0000;
      bits_left <= 6'h00;
      phase <= 1'b0;
      byte_idx <= 2'h0;
      port_pins_out <= bridge_pkg::PINS_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          byte_idx <= 2'h0;
          if (rx_byte.valid) begin
            cmd <= rx_byte.data;
            if (is_write(rx_byte.data)) begin
              state <= ST_COLLECT; // three data bytes must follow [R2]
            end else if (is_read(rx_byte.data)) begin
              shreg <= {rx_byte.data, bridge_pkg::WORD_RESET};
              bits_left <= bridge_pkg::READ_CMD_BITS;
              phase <= 1'b0;
              port_pins_out.select_low <= 1'b0;
              state <= ST_CMD_SHIFT;
            end
          end
        end
        ST_COLLECT: begin
          if (rx_byte.valid) begin
            word <= next_word; // [R3]
            byte_idx <= byte_idx + 2'h1;
            if (byte_idx == bridge_pkg::LAST_BYTE) begin
              shreg <= {cmd, next_word}; // [R2]
              bits_left <= bridge_pkg::WRITE_SHIFT_BITS;
              phase <= 1'b0;
              port_pins_out.select_low <= 1'b0;
              state <= ST_CMD_SHIFT;
            end
          end
        end
        ST_CMD_SHIFT, ST_DATA_SHIFT: begin
          if (tick) begin
            if (!phase) begin
              port_pins_out.shift_clock <= 1'b0; // falling edge, converter moves data [R15]
              if (bits_left == 6'h00) begin
                port_pins_out.serial_in_line <= 1'b0;
                if (state == ST_DATA_SHIFT || is_write(cmd)) begin
                  // releasing select lets the converter float its output [R9]
                  port_pins_out.select_low <= 1'b1;
                  byte_idx <= 2'h0;
                  state <= (state == ST_DATA_SHIFT) ? ST_REPLY : ST_IDLE;
                end else if (cmd == bridge_pkg::READ_CONV) begin
                  state <= ST_WAIT_READY;
                end else begin
                  bits_left <= bridge_pkg::READ_DATA_BITS; // calibration value [R8]
                  state <= ST_DATA_SHIFT;
                end
              end else begin
                port_pins_out.serial_in_line <= (state == ST_CMD_SHIFT) & shreg[31];
                phase <= 1'b1;
              end
            end else begin
              port_pins_out.shift_clock <= 1'b1; // one pulse per bit [R10]
              shreg <= {shreg[30:0], 1'b0};
              if (state == ST_DATA_SHIFT) begin
                word <= {word[22:0], serial_out_sync}; // msb of the result comes first [R8]
              end
              bits_left <= bits_left - 6'h01;
              phase <= 1'b0;
            end
          end
        end
        ST_WAIT_READY: begin
          // ready low marks a fresh result; high means shifting or busy [R6] [R7]
          if (!rdy_sync) begin
            bits_left <= bridge_pkg::READ_DATA_BITS; // 24 bits well inside 20 ms [R12]
            phase <= 1'b0;
            state <= ST_DATA_SHIFT;
          end
        end
        ST_REPLY: begin
          if (tx_ready) begin
            word <= {8'h00, word[23:8]}; // lowest byte goes out first [R16] [R3]
            byte_idx <= byte_idx + 2'h1;
            if (byte_idx == bridge_pkg::LAST_BYTE) begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // rs232_register_bridge

// ### verif/bridge_monitor.sv
// assertion checker watching the register bridge ports
`timescale 1ns/1ps
module bridge_monitor #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic host_tx_out,
  input wire bridge_pkg::port_pins_t port_pins_out,
  input wire logic port_wire_select_out,
  input wire logic converter_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ---------------------------------------------------------
  // port, reset and host line checks
  // ---------------------------------------------------------
  // bits stand at least BIT_CYCLES, which the bench keeps at 16 or more
  sequence clk_low_8; !port_pins_out.shift_clock [*8]; endsequence
  sequence tx_low_8; !host_tx_out [*8]; endsequence
  chk_reset_idle: assert property ($fell(reset_in) |->
    port_pins_out == bridge_pkg::PINS_IDLE && host_tx_out && converter_reset_out)
    else $error("pins not idle at reset release");
  chk_conv_reset_drop: assert property (!reset_in [*2] |-> !converter_reset_out)
    else $error("converter reset still high");
  chk_wire_select_low: assert property (!port_wire_select_out)
    else $error("wire select not low");
  chk_clock_in_frame: assert property (port_pins_out.shift_clock |->
    !port_pins_out.select_low) else $error("shift clock outside frame");
  chk_idle_pins: assert property (port_pins_out.select_low |->
    !port_pins_out.shift_clock && !port_pins_out.serial_in_line) else $error("pins not idle");
  chk_clock_high_time: assert property ($rose(port_pins_out.shift_clock) |->
    ##50 $fell(port_pins_out.shift_clock)) else $error("shift clock high time");
  chk_clock_low_time: assert property ($fell(port_pins_out.shift_clock) |-> clk_low_8)
    else $error("shift clock low time");
  chk_tx_bit_hold: assert property ($fell(host_tx_out) |-> tx_low_8)
    else $error("host bit too short");
  chk_reply_after_port: assert property (!host_tx_out |-> port_pins_out.select_low)
    else $error("reply during port transfer");
endmodule // bridge_monitor

bind rs232_register_bridge bridge_monitor #(.BIT_CYCLES(BIT_CYCLES)) i_bridge_monitor (
  .clk_in(clk_in), .reset_in(reset_in), .host_tx_out(host_tx_out),
  .port_pins_out(port_pins_out), .port_wire_select_out(port_wire_select_out),
  .converter_reset_out(converter_reset_out));

// ### verif/converter_model.sv
// behavioural model of the converter serial port
`timescale 1ns/1ps
module converter_model #(
  parameter logic [23:0] CONV_WORD = 24'hC3_5A96,
  parameter int READY_DELAY = 300
) (
  input wire logic clk_in,
  input wire bridge_pkg::port_pins_t pins_in,
  output logic result_ready_low_out,
  output logic serial_out_line_out,
  output logic [7:0] last_cmd_out,
  output logic [23:0] last_word_out
);
  logic [23:0] regs [8];
  logic [31:0] shift_in;
  logic [23:0] out_word;
  logic [5:0] cnt = 6'h00;
  logic prev_clk = 1'b0;
  logic reading = 1'b0;
  logic conv = 1'b0;
  int wait_cnt = 0;
  initial begin
    result_ready_low_out = 1'b1;
    serial_out_line_out = 1'b0;
  end
  // ---------------------------------------------------------
  // port behaviour
  // ---------------------------------------------------------
  // a shortened ready delay stands in for the long conversion period
  always @(posedge clk_in) begin
    prev_clk <= pins_in.shift_clock;
    if (wait_cnt == 1) result_ready_low_out <= 1'b0;
    if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    if (pins_in.select_low) begin
      cnt <= 6'h00;
      reading <= 1'b0;
      conv <= 1'b0;
      // the 24th result clock has fallen, so the filter restarts its period
      if (cnt == 6'h20 && conv) wait_cnt <= READY_DELAY;
      serial_out_line_out <= !serial_out_line_out; // floating line never holds
    end else if (pins_in.shift_clock && !prev_clk) begin
      shift_in <= {shift_in[30:0], pins_in.serial_in_line}; // one bit per clock
      cnt <= cnt + 6'h01;
      if (cnt == 6'h07 && !shift_in[6]) begin
        reading <= 1'b1;
        if (shift_in[6:0] == 7'h28 && !pins_in.serial_in_line) begin
          out_word <= CONV_WORD; // command picks the data source
          conv <= 1'b1;
          wait_cnt <= READY_DELAY;
        end else begin
          out_word <= regs[{shift_in[1:0], pins_in.serial_in_line}];
        end
      end
      if (cnt == 6'h1F && shift_in[30]) begin
        regs[shift_in[25:23]] <= {shift_in[22:0], pins_in.serial_in_line};
        last_cmd_out <= shift_in[30:23];
        last_word_out <= {shift_in[22:0], pins_in.serial_in_line};
      end
      if (cnt == 6'h1F) result_ready_low_out <= 1'b1; // all data out
    end else if (!pins_in.shift_clock && prev_clk && reading) begin
      serial_out_line_out <= out_word[23];
      out_word <= {out_word[22:0], 1'b0};
    end
  end
endmodule // converter_model

// ### verif/testbench.sv
// self-checking bench for the serial-link register bridge
`timescale 1ns/1ps
module testbench;
  localparam int BIT = 16;
  localparam logic [23:0] CONV = 24'hC3_5A96;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic host_rx_in = 1'b1;
  logic host_tx_out, ready_low, serial_out, wire_sel, conv_reset;
  bridge_pkg::port_pins_t pins;
  logic [7:0] last_cmd;
  logic [23:0] last_word;
  int num_errors = 0;
  int check_count = 0;

  rs232_register_bridge #(.BIT_CYCLES(BIT)) i_rs232_register_bridge (.clk_in(clk_in),
    .reset_in(reset_in), .host_rx_in(host_rx_in), .host_tx_out(host_tx_out),
    .result_ready_low_in(ready_low), .serial_out_line_in(serial_out), .port_pins_out(pins),
    .port_wire_select_out(wire_sel), .converter_reset_out(conv_reset));
  converter_model #(.CONV_WORD(CONV)) i_converter_model (.clk_in(clk_in), .pins_in(pins),
    .result_ready_low_out(ready_low), .serial_out_line_out(serial_out), .last_cmd_out(last_cmd),
    .last_word_out(last_word));

  initial begin
    forever #2.5 clk_in = !clk_in;
  end
  // ---------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------
  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // bounded wait for a reply start or the end of a port frame
  task automatic wait_for(input bit tx_low);
    int n;
    n = 0;
    while ((tx_low ? host_tx_out !== 1'b0 : pins.select_low !== 1'b1) && n < 20000) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 20000) begin
      check(24'h1, 24'h0);
      end_of_test();
    end
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_rx_in = f[i]; // start, lsb first, one stop
      repeat (BIT) @(negedge clk_in);
    end
  endtask
  task automatic get_byte(output logic [7:0] b);
    wait_for(1'b1);
    repeat (BIT / 2) @(negedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge clk_in);
      b[i] = host_tx_out;
    end
    repeat (BIT) @(negedge clk_in);
    check({23'h0, host_tx_out}, 24'h1);
  endtask
  task automatic write_reg(input logic [7:0] code, input logic [23:0] w);
    send_byte(code);
    for (int i = 0; i < 3; i++) send_byte(w[8*i +: 8]); // low byte first
    wait_for(1'b0);
    check(last_word, w);
    check({16'h0, last_cmd}, {16'h0, code});
  endtask
  task automatic get_word(input logic [23:0] w);
    logic [7:0] b;
    for (int i = 0; i < 3; i++) begin
      get_byte(b);
      check({16'h0, b}, {16'h0, w[8*i +: 8]});
    end
  endtask
  // no reply and no port frame may appear for n cycles
  task automatic quiet(input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge clk_in);
      if (host_tx_out !== 1'b1 || pins.select_low !== 1'b1) bad = 1'b1;
    end
    check({23'h0, bad}, 24'h0);
  endtask
  function automatic logic [23:0] wval(input int i);
    return {4'h1, i[3:0], 4'hA, i[3:0], 8'h3C ^ i[7:0]};
  endfunction
  // ---------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------
  task automatic t_reset();
    check({23'h0, conv_reset}, 24'h1);
    reset_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check({20'h0, conv_reset, pins}, {21'h0, bridge_pkg::PINS_IDLE});
    check({22'h0, wire_sel, host_tx_out}, 24'h1);
  endtask
  // every write code, then every calibration read back to back
  task automatic t_regs();
    for (int i = 1; i < 7; i++) write_reg(8'hD0 + 8'(i), wval(i));
    for (int i = 1; i < 7; i++) begin
      send_byte(8'h50 + 8'(i));
      get_word(wval(i));
    end
  endtask
  task automatic t_conv();
    send_byte(8'h50); // waits for the ready line
    get_word(CONV);
  endtask
  // unknown codes ignored; a byte sent mid-command is dropped
  task automatic t_refused();
    send_byte(8'h57);
    send_byte(8'hD7);
    send_byte(8'h4F);
    quiet(300);
    send_byte(8'h52);
    send_byte(8'h51);
    get_word(wval(2));
    quiet(400);
  endtask

  initial begin
    repeat (4) @(negedge clk_in);
    t_reset();
    t_regs();
    t_conv();
    t_refused();
    end_of_test();
  end
endmodule // testbench
